// File: bench/tb_tbpwm_top.sv
// self-checking bench for the timer1 buzzer and pwm block
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_tbpwm_top;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [6:0] adr = 7'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] q;
   logic [31:0] rdat;
   logic wreq;
   logic [2:0] drv;
   logic [2:0] oe;
   logic [2:0] pad;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   always #20 clk_sys_in = ~clk_sys_in;
   tbpwm_top u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wreq), .port_pin_0_out(drv[0]), .port_pin_0_oe_out(oe[0]), .port_pin_1_out(drv[1]),
      .port_pin_1_oe_out(oe[1]), .port_pin_2_out(drv[2]), .port_pin_2_oe_out(oe[2]));
   tbpwm_pins u_pins (.drv_in(drv), .oe_in(oe), .pad_out(pad));
   task automatic report_and_stop;
      if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop;
      end
   end
   task automatic acc(input logic w, input logic [4:0] i, input logic [7:0] d);
      rd <= !w;
      wr <= w;
      adr <= {i, 2'b00};
      wd <= {24'h0, d};
      do @(posedge clk_sys_in); while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   // lets the pin stage settle, then counts high pad cycles
   task automatic hi(input int k, input int n, output int c);
      c = 0;
      repeat (n + 4) @(posedge clk_sys_in);
      repeat (n) @(posedge clk_sys_in) c += pad[k];
   endtask
   task automatic t_presc;
      logic [31:0] a;
      acc(0, 5'h04, 8'h00);
      a = q;
      acc(0, 5'h04, 8'h00);
      `CHK("presc_live", 1'b1, a !== q)
      acc(1, 5'h02, 8'h08);
      acc(0, 5'h04, 8'h00);
      a = q;
      acc(1, 5'h04, 8'h00);
      acc(0, 5'h04, 8'h00);
      `CHK("presc_ro", a, q)
      acc(0, 5'h06, 8'h00);
      `CHK("unmapped", 32'h0, q)
   endtask
   task automatic t_pwm;
      int c;
      acc(1, 5'h01, 8'h03);
      acc(1, 5'h0D, 8'h00);
      acc(1, 5'h00, 8'h13);
      acc(1, 5'h0C, 8'h05);
      acc(1, 5'h12, 8'h00);
      acc(1, 5'h13, 8'h04);
      acc(1, 5'h0A, 8'h80);
      acc(1, 5'h11, 8'hC0);
      hi(0, 40, c);
      `CHK("pwm_b", 10, c)
      hi(1, 40, c);
      `CHK("pwm_c", 32, c)
      acc(1, 5'h0A, 8'hC0);
      hi(0, 40, c);
      `CHK("pwm_b_low", 30, c)
   endtask
   task automatic t_buzz;
      int c;
      int e;
      for (int k = 0; k < 8; k++) begin
         acc(1, 5'h05, {4'h8, 1'b1, k[2:0]});
         hi(2, 20, c);
         e = 0;
         for (int v = 0; v < 20; v++) e += (v >> k) & 1;
         `CHK("tone", e, c)
      end
      acc(1, 5'h05, 8'h08);
      hi(2, 0, c);
      `CHK("buzz_off", 2'b00, {oe[2], pad[2]})
      acc(1, 5'h02, 8'h00);
      acc(1, 5'h05, 8'h80);
      hi(2, 20, c);
      `CHK("tone_presc", 10, c)
   endtask
   initial begin
      repeat (3) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      `CHK("reset_oe", 4'h8, {wreq, oe})
      t_presc;
      t_pwm;
      t_buzz;
      report_and_stop;
   end
endmodule

// File: bench/tbpwm_pins.sv
// pad model of the loads on the three port pins
`timescale 1ns/1ns
module tbpwm_pins (
   // pin drivers
   input wire logic [2:0] drv_in,
   input wire logic [2:0] oe_in,
   // pad levels
   output logic [2:0] pad_out
);
   // an undriven pin falls to the pull-down level
   assign pad_out = oe_in & drv_in;
endmodule

// File: bench/tbpwm_top_asserts.sv
// bus handshake and pin enable checker
`timescale 1ns/1ns
module tbpwm_chk (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // bus
   input wire logic [6:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // pin enables
   input wire logic port_pin_0_oe_out,
   input wire logic port_pin_1_oe_out,
   input wire logic port_pin_2_oe_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("no answer");
   chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("wait low too long");
   chk_idle_wait: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
      else $error("answer without request");
   chk_upper_zero: assert property (avs_readdata_out[31:8] == 24'h0)
      else $error("read data upper bits set");
   chk_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == 7'h18
      |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
   chk_oe0_cause: assert property ($changed(port_pin_0_oe_out) |->
      $past(avs_address_in) == 7'h28 || $past(avs_address_in, 2) == 7'h28) else $error("pin 0 enable moved");
   chk_oe1_cause: assert property ($changed(port_pin_1_oe_out) |->
      $past(avs_address_in) == 7'h44 || $past(avs_address_in, 2) == 7'h44) else $error("pin 1 enable moved");
   chk_oe2_cause: assert property ($changed(port_pin_2_oe_out) |->
      $past(avs_address_in) == 7'h14 || $past(avs_address_in, 2) == 7'h14) else $error("pin 2 enable moved");
endmodule
bind tbpwm_top tbpwm_chk u_chk (.clk_sys_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
   .avs_readdata_out, .avs_waitrequest_out, .port_pin_0_oe_out, .port_pin_1_oe_out, .port_pin_2_oe_out);

// File: core/tbpwm_consts.svh
// register offsets, field positions and reset values for the timer1 buzzer/pwm block
`ifndef TBPWM_CONSTS_SVH
`define TBPWM_CONSTS_SVH
`define TBPWM_IDX_DOWN_LOW 5'h00
`define TBPWM_IDX_CTRL 5'h01
`define TBPWM_IDX_PRESC_CTRL 5'h02
`define TBPWM_IDX_PRESC 5'h04
`define TBPWM_IDX_BUZZ 5'h05
`define TBPWM_IDX_PWMB_CTRL 5'h0A
`define TBPWM_IDX_PWMB_DUTY 5'h0C
`define TBPWM_IDX_HIGH 5'h0D
`define TBPWM_IDX_PWMC_CTRL 5'h11
`define TBPWM_IDX_PWMC_HIGH 5'h12
`define TBPWM_IDX_PWMC_DUTY 5'h13
`define TBPWM_BIT_OEN 7
`define TBPWM_BIT_OAL 6
`define TBPWM_BIT_BUZ_EN 7
`define TBPWM_BIT_TMR_EN 0
`define TBPWM_BIT_PS_DIS 3
`define TBPWM_RST_PRESC 8'hFF
`define TBPWM_RST_BUZZ 8'h0F
`define TBPWM_RST_CTRL 8'h01
`define TBPWM_RST_PRESC_CTRL 8'h07
`define TBPWM_RST_PERIOD 10'h3FF
`define TBPWM_RST_DUTY 10'h200
`define TBPWM_RST_HIGH 8'h38
`define TBPWM_RST_PWMC_HIGH 2'h2
`endif

// File: core/tbpwm_pkg.sv
// types shared by the timer1 buzzer/pwm block
package tbpwm_pkg;
   typedef struct packed {
      logic output_enable;
      logic active_low;
      logic [9:0] duty;
   } tbpwm_chan_t;
   typedef struct packed {
      logic read;
      logic write;
      logic [6:0] address;
      logic [31:0] writedata;
   } tbpwm_req_t;
endpackage

// File: core/tbpwm_top.sv
// timer1 down counter, prescaler, buzzer and two pwm channels behind an avalon-mm slave
`timescale 1ns/1ns
`include "tbpwm_consts.svh"
module tbpwm_top (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // avalon-mm slave, word addressed by byte address bits 6:2
   input wire logic [6:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // port pins
   output logic port_pin_0_out,
   output logic port_pin_0_oe_out,
   output logic port_pin_1_out,
   output logic port_pin_1_oe_out,
   output logic port_pin_2_out,
   output logic port_pin_2_oe_out
);
   tbpwm_pkg::tbpwm_req_t req;
   tbpwm_pkg::tbpwm_chan_t chan_b;
   tbpwm_pkg::tbpwm_chan_t chan_c;
   logic [7:0] ctrl;
   logic [7:0] presc_ctrl;
   logic [7:0] buzz;
   logic [7:0] down_low;
   logic [7:0] high_bits;
   logic [1:0] pwmc_high;
   logic [7:0] pwmb_duty_low;
   logic [7:0] pwmc_duty_low;
   logic [7:0] presc;
   logic [9:0] count;
   logic [7:0] presc_prev;
   logic ack;
   logic [7:0] pwmb_ctrl_q;
   logic [7:0] pwmc_ctrl_q;

   // bus decode: one wait state, answer on the second cycle of a request
   assign req = '{read: avs_read_in, write: avs_write_in, address: avs_address_in, writedata: avs_writedata_in};
   wire [4:0] idx = req.address[6:2];
   wire lane0 = avs_byteenable_in[0];
   wire wr_go = req.write & ack & lane0;
   wire wr_down_low = wr_go & (idx == `TBPWM_IDX_DOWN_LOW);
   wire wr_ctrl = wr_go & (idx == `TBPWM_IDX_CTRL);
   wire wr_presc_ctrl = wr_go & (idx == `TBPWM_IDX_PRESC_CTRL);
   wire wr_buzz = wr_go & (idx == `TBPWM_IDX_BUZZ);
   wire wr_pwmb_ctrl = wr_go & (idx == `TBPWM_IDX_PWMB_CTRL);
   wire wr_pwmb_duty = wr_go & (idx == `TBPWM_IDX_PWMB_DUTY);
   wire wr_high = wr_go & (idx == `TBPWM_IDX_HIGH);
   wire wr_pwmc_ctrl = wr_go & (idx == `TBPWM_IDX_PWMC_CTRL);
   wire wr_pwmc_high = wr_go & (idx == `TBPWM_IDX_PWMC_HIGH);
   wire wr_pwmc_duty = wr_go & (idx == `TBPWM_IDX_PWMC_DUTY);

   // readable state; write-only registers read as zero
   wire [7:0] rd_byte = (idx == `TBPWM_IDX_PRESC) ? presc :
      (idx == `TBPWM_IDX_DOWN_LOW) ? count[7:0] :
      (idx == `TBPWM_IDX_CTRL) ? {5'h00, ctrl[2:0]} :
      (idx == `TBPWM_IDX_PRESC_CTRL) ? {2'h0, presc_ctrl[5:0]} :
      (idx == `TBPWM_IDX_HIGH) ? {2'h0, high_bits[5:4], 2'h0, count[9:8]} : 8'h00;

   // timing strobes
   wire timer_en = ctrl[`TBPWM_BIT_TMR_EN];
   wire presc_on = ~presc_ctrl[`TBPWM_BIT_PS_DIS];
   wire [2:0] presc_sel = presc_ctrl[2:0];
   wire [7:0] presc_next = presc - 8'h01;
   wire [7:0] presc_fall = presc_prev & ~presc;
   wire presc_tick = presc_on ? presc_fall[presc_sel] : 1'b1;
   wire tick = timer_en & presc_tick;
   wire [9:0] period = {high_bits[5:4], down_low};
   wire one_shot = ctrl[2];
   wire reload_sel = ctrl[1];
   wire underflow = (count == 10'h000);
   wire [9:0] next_count = ~tick ? count :
      ~underflow ? count - 10'h001 :
      one_shot ? count :
      reload_sel ? period : `TBPWM_RST_PERIOD;

   wire [3:0] tone_sel = buzz[3:0];
   wire tone = tone_sel[3] ? count[tone_sel[2:0]] : ~presc[tone_sel[2:0]];
   wire b_active = (count < chan_b.duty);
   wire c_active = (count < chan_c.duty);
   wire b_level = b_active ^ chan_b.active_low;
   wire c_level = c_active ^ chan_c.active_low;

   assign chan_b.output_enable = pwmb_ctrl_q[`TBPWM_BIT_OEN];
   assign chan_b.active_low = pwmb_ctrl_q[`TBPWM_BIT_OAL];
   assign chan_b.duty = {high_bits[3:2], pwmb_duty_low};
   assign chan_c.output_enable = pwmc_ctrl_q[`TBPWM_BIT_OEN];
   assign chan_c.active_low = pwmc_ctrl_q[`TBPWM_BIT_OAL];
   assign chan_c.duty = {pwmc_high, pwmc_duty_low};

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ack <= 1'b0;
         avs_readdata_out <= 32'h0000_0000;
         avs_waitrequest_out <= 1'b1;
      end else begin
         ack <= (req.read | req.write) & ~ack;
         avs_waitrequest_out <= ~((req.read | req.write) & ~ack);
         avs_readdata_out <= {24'h000000, rd_byte};
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ctrl <= `TBPWM_RST_CTRL;
         presc_ctrl <= `TBPWM_RST_PRESC_CTRL;
         buzz <= `TBPWM_RST_BUZZ;
         down_low <= 8'hFF;
         high_bits <= `TBPWM_RST_HIGH;
         pwmc_high <= `TBPWM_RST_PWMC_HIGH;
         pwmb_duty_low <= 8'h00;
         pwmc_duty_low <= 8'h00;
         pwmb_ctrl_q <= 8'h00;
         pwmc_ctrl_q <= 8'h00;
      end else begin
         if (wr_ctrl) ctrl <= req.writedata[7:0];
         if (wr_presc_ctrl) presc_ctrl <= req.writedata[7:0];
         if (wr_buzz) buzz <= req.writedata[7:0];
         if (wr_down_low) down_low <= req.writedata[7:0];
         if (wr_high) high_bits <= req.writedata[7:0];
         if (wr_pwmc_high) pwmc_high <= req.writedata[1:0];
         if (wr_pwmb_duty) pwmb_duty_low <= req.writedata[7:0];
         if (wr_pwmc_duty) pwmc_duty_low <= req.writedata[7:0];
         if (wr_pwmb_ctrl) pwmb_ctrl_q <= req.writedata[7:0];
         if (wr_pwmc_ctrl) pwmc_ctrl_q <= req.writedata[7:0];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         presc <= `TBPWM_RST_PRESC;
         presc_prev <= `TBPWM_RST_PRESC;
         count <= `TBPWM_RST_PERIOD;
      end else begin
         presc_prev <= presc;
         if (timer_en & presc_on) presc <= presc_next;
         if (wr_down_low) count <= {high_bits[5:4], req.writedata[7:0]};
         else count <= next_count;
      end
   end

   // pins driven only when their function is enabled
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         port_pin_0_out <= 1'b0;
         port_pin_0_oe_out <= 1'b0;
         port_pin_1_out <= 1'b0;
         port_pin_1_oe_out <= 1'b0;
         port_pin_2_out <= 1'b0;
         port_pin_2_oe_out <= 1'b0;
      end else begin
         port_pin_0_out <= chan_b.output_enable & b_level;
         port_pin_0_oe_out <= chan_b.output_enable;
         port_pin_1_out <= chan_c.output_enable & c_level;
         port_pin_1_oe_out <= chan_c.output_enable;
         port_pin_2_out <= buzz[`TBPWM_BIT_BUZ_EN] & tone;
         port_pin_2_oe_out <= buzz[`TBPWM_BIT_BUZ_EN];
      end
   end
endmodule
